// ==== hdl/switch_pair.sv ====
// One pair of protected switches: gating, shutdown latch and status.
// Assumes PWM and sense inputs are already synchronised to CLK_IN.
module switch_pair
    import side_switch_pkg::*;
#(
    parameter bit FORCE_OFF_LOW_POWER = 1'b0
) (
    input  wire logic           clk_in,
    input  wire logic           reset_n_in,
    input  wire switch_ctrl_t   ctrl_in,
    input  wire logic           ctrl_write_in,
    input  wire switch_sense_t  sense_in,
    input  wire logic           overvoltage_in,
    input  wire logic           hv_shutdown_enable_in,
    input  wire logic           low_power_in,
    input  wire logic           pwm_in,
    output logic [NUM_OUT-1:0]  drive_out,
    output switch_status_t      status_out,
    output logic                shutdown_out,
    output logic                ot_event_out
);
    switch_state_t      state_ff;
    switch_state_t      nxt_state;
    logic               ot_prev_ff;
    logic               ot_shut_ff;
    logic               hv_shut_ff;
    logic [NUM_OUT-1:0] drive_ff;
    logic [NUM_OUT-1:0] nxt_drive;
    switch_status_t     status_ff;
    logic               hv_cond;

    assign hv_cond = overvoltage_in && hv_shutdown_enable_in;
    assign ot_event_out = sense_in.over_temp && !ot_prev_ff;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ot_prev_ff <= 1'b0;
        end else begin
            ot_prev_ff <= sense_in.over_temp;
        end
    end

    // Shutdown latches; a write while the fault persists must not re-enable
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ot_shut_ff <= 1'b0;
        end else if (sense_in.over_temp) begin
            ot_shut_ff <= 1'b1;
        end else if (ctrl_write_in) begin
            ot_shut_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            hv_shut_ff <= 1'b0;
        end else if (hv_cond) begin
            hv_shut_ff <= 1'b1;
        end else if (ctrl_write_in) begin
            hv_shut_ff <= 1'b0;
        end
    end

    assign shutdown_out = ot_shut_ff || hv_shut_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SW_RUN:     if (sense_in.over_temp || hv_cond) nxt_state = SW_SHUT;
            SW_SHUT:    if (!sense_in.over_temp && !hv_cond && ctrl_write_in) begin
                nxt_state = SW_CLEARED;
            end
            SW_CLEARED: nxt_state = SW_RUN;
            default:    nxt_state = SW_RUN;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_ff <= SW_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Output gating; PWM only acts when enable is also set
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            if (!ctrl_in.enable[i]) begin
                nxt_drive[i] = 1'b0;
            end else if (ctrl_in.pwm_select[i]) begin
                nxt_drive[i] = pwm_in;
            end else begin
                nxt_drive[i] = 1'b1;
            end
        end
        if (sense_in.over_temp || hv_cond || shutdown_out) begin
            nxt_drive = OUTS_OFF;
        end
        if (FORCE_OFF_LOW_POWER && low_power_in) begin
            nxt_drive = OUTS_OFF;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            drive_ff <= OUTS_OFF;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            status_ff <= '0;
        end else if (ot_shut_ff) begin
            status_ff.open_load     <= FLAGS_ALL;
            status_ff.current_limit <= FLAGS_ALL;
        end else begin
            status_ff.open_load     <= sense_in.open_load;
            status_ff.current_limit <= sense_in.current_limit;
        end
    end

    assign drive_out  = drive_ff;
    assign status_out = status_ff;

    property p_ot_off;
        @(posedge clk_in) disable iff (!reset_n_in)
        sense_in.over_temp |=> (drive_out == OUTS_OFF);
    endproperty
    a_ot_off: assert property (p_ot_off) else $error("Outputs on during over-temperature");

    property p_hv_off;
        @(posedge clk_in) disable iff (!reset_n_in)
        hv_cond |=> (drive_out == OUTS_OFF);
    endproperty
    a_hv_off: assert property (p_hv_off) else $error("Outputs on during high voltage");

    property p_disabled_off;
        @(posedge clk_in) disable iff (!reset_n_in)
        !ctrl_in.enable[OUT_A] |=> !drive_out[OUT_A];
    endproperty
    a_disabled_off: assert property (p_disabled_off) else $error("Disabled output on");

    property p_stay_off;
        @(posedge clk_in) disable iff (!reset_n_in)
        (shutdown_out && !ctrl_write_in) |=> shutdown_out;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("Shutdown cleared without write");

    property p_shut_state;
        @(posedge clk_in) disable iff (!reset_n_in)
        (state_ff == SW_SHUT) |-> shutdown_out;
    endproperty
    a_shut_state: assert property (p_shut_state) else $error("Shut state without latch");

    property p_thermal_flags;
        @(posedge clk_in) disable iff (!reset_n_in)
        ot_shut_ff |=> (status_out.open_load == FLAGS_ALL && status_out.current_limit == FLAGS_ALL);
    endproperty
    a_thermal_flags: assert property (p_thermal_flags) else $error("Thermal flags not set");

    property p_pwm_follow;
        @(posedge clk_in) disable iff (!reset_n_in)
        (ctrl_in.enable[OUT_B] && ctrl_in.pwm_select[OUT_B] && !shutdown_out
         && !sense_in.over_temp && !hv_cond && !(FORCE_OFF_LOW_POWER && low_power_in))
        |=> (drive_out[OUT_B] == $past(pwm_in));
    endproperty
    a_pwm_follow: assert property (p_pwm_follow) else $error("PWM not followed");

    c_shut_then_clear: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        shutdown_out ##[1:20] !shutdown_out);
    c_pwm_on: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        ctrl_in.pwm_select[OUT_A] && drive_out[OUT_A]);
endmodule

// ==== hdl/side_switch_pkg.sv ====
// Shared constants and carrier types for the side switch control block.
// Assumes a single 50 MHz system clock and synchronous active-low reset.
package side_switch_pkg;
    localparam int  CLK_PERIOD_NS    = 20;
    localparam int  SYNC_STAGES      = 2;
    localparam int  NUM_OUT          = 2;
    localparam int  OUT_A            = 0;
    localparam int  OUT_B            = 1;
    localparam logic [NUM_OUT-1:0] OUTS_OFF = 2'h0;
    localparam logic [NUM_OUT-1:0] FLAGS_ALL = 2'h3;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_STOP   = 2'h1,
        MODE_SLEEP  = 2'h3
    } power_mode_t;

    typedef enum logic [1:0] {
        SW_RUN      = 2'h0,
        SW_SHUT     = 2'h1,
        SW_CLEARED  = 2'h3
    } switch_state_t;

    // One control register image: per-output enable and PWM select
    typedef struct packed {
        logic [NUM_OUT-1:0] enable;
        logic [NUM_OUT-1:0] pwm_select;
    } switch_ctrl_t;

    // Analog sense inputs for one pair of switches
    typedef struct packed {
        logic [NUM_OUT-1:0] open_load;
        logic [NUM_OUT-1:0] current_limit;
        logic               over_temp;
    } switch_sense_t;

    // Status register image for one pair
    typedef struct packed {
        logic [NUM_OUT-1:0] open_load;
        logic [NUM_OUT-1:0] current_limit;
    } switch_status_t;
endpackage

// ==== hdl/side_switch_control.sv ====
// Top level: two high side and two low side switch controllers plus IRQ.
// Assumes PWM, sense and reset pin inputs are asynchronous to CLK_IN.

module side_switch_control
    import side_switch_pkg::*;
(
    input  wire logic          CLK_IN,
    input  wire logic          RESET_N_IN,
    input  wire switch_ctrl_t  HIGH_OUT_CONTROL_REG_IN,
    input  wire logic          HIGH_OUT_CONTROL_WRITE_IN,
    input  wire switch_ctrl_t  LOW_OUT_CONTROL_REG_IN,
    input  wire logic          LOW_OUT_CONTROL_WRITE_IN,
    input  wire logic          OVERVOLTAGE_SHUTDOWN_ENABLE_IN,
    input  wire power_mode_t   POWER_MODE_IN,
    input  wire logic          HIGH_OUT_IRQ_MASK_IN,
    input  wire logic          LOW_OUT_IRQ_MASK_IN,
    input  wire logic          IRQ_ACK_READ_IN,
    input  wire logic          DIRECT_PWM_INPUT_IN,
    input  wire switch_sense_t HIGH_SENSE_IN,
    input  wire switch_sense_t LOW_SENSE_IN,
    input  wire logic          OVERVOLTAGE_IN,
    input  wire logic          RESET_PIN_N_IN,
    output logic [1:0]         HIGH_OUT_DRIVE_OUT,
    output logic [1:0]         LOW_OUT_DRIVE_OUT,
    output switch_status_t     HIGH_OUT_STATUS_REG_OUT,
    output switch_status_t     LOW_OUT_STATUS_REG_OUT,
    output logic [1:0]         INTERRUPT_SOURCE_REG_OUT,
    output logic               IRQ_N_OUT
);
    localparam int SENSE_W = 2 * $bits(switch_sense_t) + 3;

    logic [SENSE_W-1:0] meta_ff;
    logic [SENSE_W-1:0] sync_ff;
    switch_sense_t      hs_sense;
    switch_sense_t      ls_sense;
    logic               pwm_sync;
    logic               ov_sync;
    logic               rst_pin_n_sync;
    logic               low_power;
    logic               hs_ot_event;
    logic               ls_ot_event;
    logic [1:0]         source_ff;
    logic               irq_ff;
    logic               nxt_irq;

    // Two-flop synchroniser on every asynchronous pin input
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= {DIRECT_PWM_INPUT_IN, OVERVOLTAGE_IN, RESET_PIN_N_IN,
                        HIGH_SENSE_IN, LOW_SENSE_IN};
            sync_ff <= meta_ff;
        end
    end

    assign {pwm_sync, ov_sync, rst_pin_n_sync, hs_sense, ls_sense} = sync_ff;
    assign low_power = (POWER_MODE_IN == MODE_STOP) || (POWER_MODE_IN == MODE_SLEEP);

    switch_pair #(
        .FORCE_OFF_LOW_POWER (1'b0)
    ) u_high (
        .clk_in                (CLK_IN),
        .reset_n_in            (RESET_N_IN),
        .ctrl_in               (HIGH_OUT_CONTROL_REG_IN),
        .ctrl_write_in         (HIGH_OUT_CONTROL_WRITE_IN),
        .sense_in              (hs_sense),
        .overvoltage_in        (ov_sync),
        .hv_shutdown_enable_in (OVERVOLTAGE_SHUTDOWN_ENABLE_IN),
        .low_power_in          (low_power),
        .pwm_in                (pwm_sync),
        .drive_out             (HIGH_OUT_DRIVE_OUT),
        .status_out            (HIGH_OUT_STATUS_REG_OUT),
        .shutdown_out          (),
        .ot_event_out          (hs_ot_event)
    );

    switch_pair #(
        .FORCE_OFF_LOW_POWER (1'b1)
    ) u_low (
        .clk_in                (CLK_IN),
        .reset_n_in            (RESET_N_IN),
        .ctrl_in               (LOW_OUT_CONTROL_REG_IN),
        .ctrl_write_in         (LOW_OUT_CONTROL_WRITE_IN),
        .sense_in              (ls_sense),
        .overvoltage_in        (ov_sync),
        .hv_shutdown_enable_in (OVERVOLTAGE_SHUTDOWN_ENABLE_IN),
        .low_power_in          (low_power),
        .pwm_in                (pwm_sync),
        .drive_out             (LOW_OUT_DRIVE_OUT),
        .status_out            (LOW_OUT_STATUS_REG_OUT),
        .shutdown_out          (),
        .ot_event_out          (ls_ot_event)
    );

    // Source bits: a new event in the acknowledge cycle wins over the clear
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            source_ff <= SYNC_RESET;
        end else begin
            source_ff[OUT_A] <= hs_ot_event || (source_ff[OUT_A] && !IRQ_ACK_READ_IN);
            source_ff[OUT_B] <= ls_ot_event || (source_ff[OUT_B] && !IRQ_ACK_READ_IN);
        end
    end

    always_comb begin
        nxt_irq = irq_ff && !IRQ_ACK_READ_IN;
        if ((hs_ot_event && HIGH_OUT_IRQ_MASK_IN) || (ls_ot_event && LOW_OUT_IRQ_MASK_IN)) begin
            nxt_irq = 1'b1;
        end
        if (!rst_pin_n_sync) begin
            nxt_irq = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign INTERRUPT_SOURCE_REG_OUT = source_ff;
    assign IRQ_N_OUT = !irq_ff;

    property p_irq_masked_hs;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (hs_ot_event && !HIGH_OUT_IRQ_MASK_IN && !ls_ot_event && !irq_ff) |=> IRQ_N_OUT;
    endproperty
    a_irq_masked_hs: assert property (p_irq_masked_hs) else $error("Masked high IRQ raised");

    property p_irq_ls;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (ls_ot_event && LOW_OUT_IRQ_MASK_IN && rst_pin_n_sync) |=> !IRQ_N_OUT;
    endproperty
    a_irq_ls: assert property (p_irq_ls) else $error("Low IRQ not raised");

    property p_irq_hold;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        (!IRQ_N_OUT && !IRQ_ACK_READ_IN && rst_pin_n_sync) |=> !IRQ_N_OUT;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("IRQ dropped before ack");

    property p_no_irq_in_reset;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        !rst_pin_n_sync |=> IRQ_N_OUT;
    endproperty
    a_no_irq_in_reset: assert property (p_no_irq_in_reset) else $error("IRQ during reset pin");

    property p_low_power_off;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        low_power |=> (LOW_OUT_DRIVE_OUT == OUTS_OFF);
    endproperty
    a_low_power_off: assert property (p_low_power_off) else $error("Low output in low power");

    property p_source_hs;
        @(posedge CLK_IN) disable iff (!RESET_N_IN)
        hs_ot_event |=> INTERRUPT_SOURCE_REG_OUT[OUT_A];
    endproperty
    a_source_hs: assert property (p_source_hs) else $error("High source not set");

    c_irq_ack: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !IRQ_N_OUT ##[1:10] IRQ_N_OUT);
    c_low_ot: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN) ls_ot_event);
endmodule

// ==== sim/mcu_model.sv ====
// Microcontroller stand-in: control images, masks, mode, acknowledge, PWM pin.
// Assumes the bench calls its tasks; every pin changes on a falling edge.
module mcu_model
    import side_switch_pkg::*;
(
    input  wire logic    clk_in,
    output switch_ctrl_t high_ctrl_out,
    output logic         high_write_out,
    output switch_ctrl_t low_ctrl_out,
    output logic         low_write_out,
    output logic         hv_enable_out,
    output power_mode_t  mode_out,
    output logic         high_mask_out,
    output logic         low_mask_out,
    output logic         ack_out,
    output logic         pwm_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        high_ctrl_out = 4'h0;
        low_ctrl_out = 4'h0;
        high_write_out = 1'b0;
        low_write_out = 1'b0;
        hv_enable_out = 1'b0;
        mode_out = MODE_NORMAL;
        high_mask_out = 1'b0;
        low_mask_out = 1'b0;
        ack_out = 1'b0;
        pwm_out = 1'b0;
    end

    // Images change as levels; the strobe only marks a register write
    task automatic write_ctrl(input logic hw, input logic lw,
                              input switch_ctrl_t h, input switch_ctrl_t l);
        @(negedge clk_in);
        high_ctrl_out = h;
        low_ctrl_out = l;
        high_write_out = hw;
        low_write_out = lw;
        @(negedge clk_in);
        high_write_out = 1'b0;
        low_write_out = 1'b0;
    endtask

    task automatic set_cfg(input logic hv, input power_mode_t m,
                           input logic hm, input logic lm, input logic p);
        @(negedge clk_in);
        hv_enable_out = hv;
        mode_out = m;
        high_mask_out = hm;
        low_mask_out = lm;
        pwm_out = p;
    endtask

    // One-cycle read acknowledge of the pending interrupt
    task automatic ack_read();
        @(negedge clk_in);
        ack_out = 1'b1;
        @(negedge clk_in);
        ack_out = 1'b0;
    endtask
endmodule

// ==== sim/test_side_switch_control.sv ====
// Self-checking bench for the side switch control block.
// Assumes the microcontroller model drives the control side pins.
module test_side_switch_control
    import side_switch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic           clk, rst_n, hwr, lwr, hve, hm, lm, ack, pwm, ov, rpin_n, irq_n;
    switch_ctrl_t   hctl, lctl, c;
    power_mode_t    mode;
    switch_sense_t  hsense, lsense;
    switch_status_t hst, lst;
    logic [1:0]     hdrv, ldrv, src, e;
    int             failures = 0;
    int             samples_checked = 0;

    mcu_model u_mcu_model (.clk_in(clk), .high_ctrl_out(hctl), .high_write_out(hwr),
        .low_ctrl_out(lctl), .low_write_out(lwr), .hv_enable_out(hve), .mode_out(mode),
        .high_mask_out(hm), .low_mask_out(lm), .ack_out(ack), .pwm_out(pwm));

    side_switch_control u_side_switch_control (.CLK_IN(clk), .RESET_N_IN(rst_n),
        .HIGH_OUT_CONTROL_REG_IN(hctl), .HIGH_OUT_CONTROL_WRITE_IN(hwr),
        .LOW_OUT_CONTROL_REG_IN(lctl), .LOW_OUT_CONTROL_WRITE_IN(lwr),
        .OVERVOLTAGE_SHUTDOWN_ENABLE_IN(hve), .POWER_MODE_IN(mode),
        .HIGH_OUT_IRQ_MASK_IN(hm), .LOW_OUT_IRQ_MASK_IN(lm), .IRQ_ACK_READ_IN(ack),
        .DIRECT_PWM_INPUT_IN(pwm), .HIGH_SENSE_IN(hsense), .LOW_SENSE_IN(lsense),
        .OVERVOLTAGE_IN(ov), .RESET_PIN_N_IN(rpin_n), .HIGH_OUT_DRIVE_OUT(hdrv),
        .LOW_OUT_DRIVE_OUT(ldrv), .HIGH_OUT_STATUS_REG_OUT(hst),
        .LOW_OUT_STATUS_REG_OUT(lst), .INTERRUPT_SOURCE_REG_OUT(src), .IRQ_N_OUT(irq_n));

    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Over-temperature on one side (0 high, 1 low) with the given mask
    task automatic ot_case(input logic side, input logic mask);
        u_mcu_model.set_cfg(1'b0, MODE_NORMAL, mask, mask, 1'b0);
        hsense = side ? 5'h00 : 5'h01;
        lsense = side ? 5'h01 : 5'h00;
        step(5);
        check(side ? {ldrv, hdrv} : {hdrv, ldrv}, 8'h03);
        check(src, side ? 8'h02 : 8'h01);
        check(irq_n, {7'h00, ~mask});
        if (!side) check(hst, 8'h0f);
        u_mcu_model.write_ctrl(~side, side, c, c);
        step(3);
        check(side ? ldrv : hdrv, 8'h00);
        hsense = 5'h00;
        lsense = 5'h00;
        step(4);
        check(side ? ldrv : hdrv, 8'h00);
        u_mcu_model.write_ctrl(~side, side, c, c);
        step(3);
        check(side ? ldrv : hdrv, 8'h03);
        check(irq_n, {7'h00, ~mask});
        u_mcu_model.ack_read();
        step(2);
        check({src, 1'b0, irq_n}, 8'h01);
    endtask

    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        hsense = 5'h00;
        lsense = 5'h00;
        ov = 1'b0;
        rpin_n = 1'b1;
        step(6);
        rst_n = 1'b1;
        step(3);
        check({hdrv, ldrv, src, 1'b0, irq_n}, 8'h01);
        check({hst, lst}, 8'h00);
        // Every enable and select image against both PWM levels
        for (int i = 0; i < 32; i++) begin
            c = switch_ctrl_t'(i[3:0]);
            u_mcu_model.set_cfg(1'b0, MODE_NORMAL, 1'b0, 1'b0, i[4]);
            u_mcu_model.write_ctrl(1'b0, 1'b0, c, c);
            step(3);
            e = c.enable & (~c.pwm_select | {2{i[4]}});
            check(hdrv, e);
            check(ldrv, e);
        end
        // PWM edge must not reach the drives within two cycles
        u_mcu_model.set_cfg(1'b0, MODE_NORMAL, 1'b0, 1'b0, 1'b0);
        step(3);
        u_mcu_model.set_cfg(1'b0, MODE_NORMAL, 1'b0, 1'b0, 1'b1);
        step(2);
        check({hdrv, ldrv}, 8'h00);
        step(1);
        check({hdrv, ldrv}, 8'h0f);
        for (int i = 0; i < 4; i++) begin
            hsense = {4'h1 << i, 1'b0};
            lsense = {4'h8 >> i, 1'b0};
            step(4);
            check(hst, 8'h01 << i);
            check(lst, 8'h08 >> i);
        end
        hsense = 5'h00;
        lsense = 5'h00;
        c = '{enable: 2'h3, pwm_select: 2'h0};
        u_mcu_model.write_ctrl(1'b0, 1'b0, c, c);
        for (int i = 0; i < 4; i++) ot_case(i[0], i[1]);
        // High supply without shutdown enable leaves the drives alone
        ov = 1'b1;
        step(4);
        check({hdrv, ldrv}, 8'h0f);
        u_mcu_model.set_cfg(1'b1, MODE_NORMAL, 1'b0, 1'b0, 1'b0);
        step(2);
        check({hdrv, ldrv}, 8'h00);
        u_mcu_model.write_ctrl(1'b1, 1'b1, c, c);
        step(3);
        check({hdrv, ldrv}, 8'h00);
        ov = 1'b0;
        step(4);
        check({hdrv, ldrv}, 8'h00);
        u_mcu_model.write_ctrl(1'b1, 1'b1, c, c);
        step(3);
        check({hdrv, ldrv}, 8'h0f);
        for (int i = 0; i < 2; i++) begin
            u_mcu_model.set_cfg(1'b0, i ? MODE_SLEEP : MODE_STOP, 1'b0, 1'b0, 1'b0);
            step(3);
            check({hdrv, ldrv}, 8'h0c);
        end
        u_mcu_model.set_cfg(1'b0, MODE_NORMAL, 1'b1, 1'b1, 1'b0);
        step(3);
        check(ldrv, 8'h03);
        // Event during a held reset pin latches but raises nothing
        rpin_n = 1'b0;
        step(3);
        hsense = 5'h01;
        step(5);
        check({src, 1'b0, irq_n}, 8'h05);
        hsense = 5'h00;
        rpin_n = 1'b1;
        step(4);
        check(irq_n, 8'h01);
        summarize();
    end
endmodule
